// *** dv/pbc_mcu_model.sv ***
`timescale 1ns/10ps
module pbc_mcu_model (
	input wire logic clk_sys_in,
	output logic word_valid_out,
	output logic [13:0] word_out,
	output logic data_out
);
	initial begin
		word_valid_out = 1'b0;
		word_out = 14'h0000;
		data_out = 1'b0;
	end
	task automatic write_word(input logic [13:0] w);
		@(negedge clk_sys_in);
		word_out = w;
		word_valid_out = 1'b1;
		@(negedge clk_sys_in);
		word_valid_out = 1'b0;
		// Stale word must not look valid
		word_out = ~w;
	endtask : write_word
	task automatic send_gaps(input int n, input int g);
		for (int i = 0; i < n; i++) begin
			repeat (g) @(negedge clk_sys_in);
			data_out = ~data_out;
		end
	endtask : send_gaps
endmodule : pbc_mcu_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
	import pbc_pkg::*;
	logic clk_sys_in;
	logic reset_in;
	logic strap_mode;
	logic word_valid_in;
	logic [13:0] word_in;
	logic data_in;
	logic processing_enable_out;
	logic receiving_out;
	logic data_out;
	logic [11:0] opc;
	logic [11:0] lim;
	logic [3:0] state_out;
	int n_mismatch = 0;
	int num_checks = 0;
	int cnt;

	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	// Strap low first, high for the last reset, so both base ratios run
	pbc_sequencer u_pbc_sequencer (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.strap_mode_in(strap_mode),
		.data_in(data_in),
		.word_valid_in(word_valid_in),
		.word_in(word_in),
		.processing_enable_out(processing_enable_out),
		.receiving_out(receiving_out),
		.data_out(data_out),
		.operating_config_register_out(opc),
		.limit_register_out(lim),
		.state_out(state_out)
	);

	pbc_mcu_model u_pbc_mcu_model (
		.clk_sys_in(clk_sys_in),
		.word_valid_out(word_valid_in),
		.word_out(word_in),
		.data_out(data_in)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_st(input logic [3:0] s, input int n);
		for (int i = 0; i < n && state_out !== s; i++) @(negedge clk_sys_in);
		chk(state_out, s);
	endtask : wait_st

	// Tolerance covers tick phase and state hand-over cycles
	task automatic count_st(input logic [3:0] s, input int exp);
		wait_st(s, 1200);
		cnt = 0;
		while (state_out === s && cnt < 70000) begin
			@(negedge clk_sys_in);
			cnt++;
		end
		chk(cnt >= exp - 24 && cnt <= exp + 24, 1'b1);
	endtask : count_st

	task automatic done(input string t);
		$display("Test %s finished", t);
	endtask : done

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	initial begin
		repeat (99000) @(posedge clk_sys_in);
		n_mismatch++;
		end_sim();
	end

	initial begin
		strap_mode = 1'b0;
		reset_in = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		reset_in = 1'b0;
		@(negedge clk_sys_in);
		chk(opc, OPC_DEFAULT);
		chk(lim, LIM_DEFAULT);
		chk(state_out, PBC_SLEEP);
		done("reset");
		// Window wide enough for either scaling reading of a 200 clock gap
		u_pbc_mcu_model.write_word(14'h02a8);
		u_pbc_mcu_model.write_word(14'h1900);
		repeat (2) @(negedge clk_sys_in);
		chk(lim, 12'h2a8);
		chk(opc, 12'h900);
		wait_st(PBC_WARMUP, 100);
		chk(processing_enable_out, 1'b1);
		wait_st(PBC_CHECK, 300);
		wait_st(PBC_WARMUP, 1200);
		chk(receiving_out, 1'b0);
		chk(data_out, 1'b0);
		done("polling");
		wait_st(PBC_CHECK, 300);
		u_pbc_mcu_model.send_gaps(1, 200);
		u_pbc_mcu_model.send_gaps(1, 40);
		wait_st(PBC_WARMUP, 300);
		chk(receiving_out, 1'b0);
		done("short gap");
		wait_st(PBC_CHECK, 300);
		// Seventh edge falls in receiving mode, so the output must go high
		u_pbc_mcu_model.send_gaps(7, 200);
		repeat (5) @(negedge clk_sys_in);
		chk(receiving_out, 1'b1);
		chk(data_out, data_in);
		u_pbc_mcu_model.write_word(14'h2000);
		repeat (3) @(negedge clk_sys_in);
		chk(receiving_out, 1'b0);
		u_pbc_mcu_model.write_word(14'h1800);
		wait_st(PBC_RECEIVE, 400);
		u_pbc_mcu_model.write_word(14'h2000);
		done("receive");
		u_pbc_mcu_model.write_word(14'h1901);
		wait_st(PBC_CHECK, 400);
		wait_st(PBC_WARMUP, 1200);
		repeat (3) @(negedge clk_sys_in);
		chk(opc, 12'h900);
		done("temporary extension");
		u_pbc_mcu_model.write_word(14'h197c);
		repeat (3000) @(negedge clk_sys_in);
		chk(state_out, PBC_SLEEP);
		chk(processing_enable_out, 1'b0);
		u_pbc_mcu_model.write_word(14'h1904);
		wait_st(PBC_WARMUP, 20000);
		count_st(PBC_SLEEP, 8192);
		u_pbc_mcu_model.write_word(14'h1906);
		count_st(PBC_SLEEP, 65536);
		done("sleep timing");
		// Mid-run reset with the strap high: warm-up stretches with the slower tick
		strap_mode = 1'b1;
		reset_in = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		reset_in = 1'b0;
		u_pbc_mcu_model.write_word(14'h1900);
		count_st(PBC_WARMUP, int'(WARMUP_CYCLES) * int'(CLK_DIV_STRAP_HIGH));
		done("strap");
		end_sim();
	end
endmodule : tb

// *** pkg/pbc_pkg.sv ***
package pbc_pkg;
	// Base clock divider ratios of the crystal oscillator, selected by the strap
	localparam logic [3:0] CLK_DIV_STRAP_LOW = 4'h8;
	localparam logic [3:0] CLK_DIV_STRAP_HIGH = 4'hc;
	// Range clock ratio in base clocks, per baud band
	localparam logic [3:0] RANGE_DIV_BAND0 = 4'h2;
	localparam logic [3:0] RANGE_DIV_BAND1 = 4'h1;
	localparam logic [3:0] RANGE_DIV_BAND2 = 4'h1;
	localparam logic [3:0] RANGE_DIV_BAND3 = 4'h1;
	// Window scale factor per baud band
	localparam logic [3:0] SCALE_BAND0 = 4'h8;
	localparam logic [3:0] SCALE_BAND1 = 4'h4;
	localparam logic [3:0] SCALE_BAND2 = 4'h2;
	localparam logic [1:0] BAND0 = 2'h0;
	localparam logic [1:0] BAND1 = 2'h1;
	localparam logic [1:0] BAND2 = 2'h2;
	// Operating configuration word, 12 bits
	localparam int OPC_BAUD_LSB = 10;
	localparam int OPC_BITCHK_LSB = 8;
	localparam int OPC_POUT_BIT = 7;
	localparam int OPC_SLEEP_LSB = 2;
	localparam int OPC_XFIXED_BIT = 1;
	localparam int OPC_XTEMP_BIT = 0;
	localparam logic [11:0] OPC_DEFAULT = 12'h22c;
	// Limit word, 12 bits: lower in high half, upper in low half
	localparam int LIM_MIN_LSB = 6;
	localparam int LIM_MAX_LSB = 0;
	localparam logic [11:0] LIM_DEFAULT = 12'h398;
	localparam logic [4:0] SLEEP_PERMANENT = 5'h1f;
	localparam logic [3:0] SLEEP_EXT_NORMAL = 4'h1;
	localparam logic [3:0] SLEEP_EXT_LONG = 4'h8;
	localparam int SLEEP_UNIT_SHIFT = 10;
	localparam logic [15:0] WARMUP_CYCLES = 16'h0010;
	// Edge-gap test counts for checked bit codes 0..3
	localparam logic [4:0] TESTS_CODE0 = 5'h00;
	localparam logic [4:0] TESTS_CODE1 = 5'h06;
	localparam logic [4:0] TESTS_CODE2 = 5'h0c;
	localparam logic [4:0] TESTS_CODE3 = 5'h12;
	typedef enum logic [3:0] {
		PBC_SLEEP = 4'h1,
		PBC_WARMUP = 4'h2,
		PBC_CHECK = 4'h4,
		PBC_RECEIVE = 4'h8
	} pbc_state_type;
endpackage : pbc_pkg

// *** rtl/pbc_divider.sv ***
`timescale 1ns/10ps
module pbc_divider (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [4:0] ratio_in,
	input wire logic enable_in,
	output logic tick_out
);
	import pbc_pkg::*;
	logic [4:0] count_q;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !enable_in) begin
			count_q <= 5'h0;
			tick_out <= 1'b0;
		end else if (count_q + 5'h1 >= ratio_in) begin
			count_q <= 5'h0;
			tick_out <= 1'b1;
		end else begin
			count_q <= count_q + 5'h1;
			tick_out <= 1'b0;
		end
	end
endmodule : pbc_divider

// *** rtl/pbc_sequencer.sv ***
`timescale 1ns/10ps
module pbc_sequencer (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic strap_mode_in,
	input wire logic data_in,
	input wire logic word_valid_in,
	input wire logic [13:0] word_in,
	output logic processing_enable_out,
	output logic receiving_out,
	output logic data_out,
	output logic [11:0] operating_config_register_out,
	output logic [11:0] limit_register_out,
	output logic [3:0] state_out
);
	import pbc_pkg::*;

	pbc_state_type state_q;
	logic [11:0] opc_q;
	logic [11:0] lim_q;
	logic strap_q;
	logic strap_taken_q;
	logic strap_sync;
	logic [1:0] strap_settle_q;
	logic base_tick;
	logic range_tick;
	logic data_sync;
	logic data_prev_q;
	logic [27:0] timer_q;
	logic [15:0] gap_q;
	logic [4:0] tests_q;
	logic fail_now;
	logic pass_now;
	logic edge_now;
	logic off_cmd_q;

	// Tests required for a checked bit code
	function automatic logic [4:0] tests_for(input logic [1:0] code);
		case (code)
			2'h0: tests_for = TESTS_CODE0;
			2'h1: tests_for = TESTS_CODE1;
			2'h2: tests_for = TESTS_CODE2;
			default: tests_for = TESTS_CODE3;
		endcase
	endfunction : tests_for

	function automatic logic [3:0] range_ratio(input logic [1:0] band);
		case (band)
			BAND0: range_ratio = RANGE_DIV_BAND0;
			BAND1: range_ratio = RANGE_DIV_BAND1;
			BAND2: range_ratio = RANGE_DIV_BAND2;
			default: range_ratio = RANGE_DIV_BAND3;
		endcase
	endfunction : range_ratio

	function automatic logic [3:0] scale_of(input logic [1:0] band);
		case (band)
			BAND0: scale_of = SCALE_BAND0;
			BAND1: scale_of = SCALE_BAND1;
			default: scale_of = SCALE_BAND2;
		endcase
	endfunction : scale_of

	wire [1:0] band = opc_q[OPC_BAUD_LSB +: 2];
	wire [4:0] sleep_cnt = opc_q[OPC_SLEEP_LSB +: 5];
	wire [5:0] lim_min = lim_q[LIM_MIN_LSB +: 6];
	wire [5:0] lim_max = lim_q[LIM_MAX_LSB +: 6];
	wire ext_long = opc_q[OPC_XFIXED_BIT] | opc_q[OPC_XTEMP_BIT];
	wire [3:0] ext_factor = ext_long ? SLEEP_EXT_LONG : SLEEP_EXT_NORMAL;
	wire [27:0] sleep_len = ({23'h0, sleep_cnt} << SLEEP_UNIT_SHIFT) * 28'(ext_factor);
	// base ratio; five bits so the widest range ratio still fits
	wire [4:0] base_ratio = 5'(strap_q ? CLK_DIV_STRAP_HIGH : CLK_DIV_STRAP_LOW);
	// window bounds in range periods, scaled
	wire [15:0] win_lo = 16'(lim_min) * 16'(scale_of(band));
	wire [15:0] win_hi = (16'(lim_max) - 16'h1) * 16'(scale_of(band));

	// Strap is a pin: it passes the synchroniser before anything reads it
	pbc_sync strap_sync_i (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.async_in(strap_mode_in),
		.sync_out(strap_sync)
	);

	// Strap is caught after reset release, never under reset
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			strap_q <= 1'b0;
			strap_taken_q <= 1'b0;
			strap_settle_q <= 2'h0;
		end else begin
			strap_settle_q <= {strap_settle_q[0], 1'b1};
			// Read once, so a bouncing pin cannot change the base tick later
			if (!strap_taken_q && strap_settle_q[1]) begin
				strap_q <= strap_sync;
				strap_taken_q <= 1'b1;
			end
		end
	end

	pbc_divider base_div (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.ratio_in(base_ratio),
		.enable_in(strap_taken_q),
		.tick_out(base_tick)
	);

	// range clock from the base tick rate
	// A band change mid-count is harmless: the divider compares with >=
	pbc_divider range_div (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.ratio_in(5'(range_ratio(band)) * base_ratio),
		.enable_in(strap_taken_q),
		.tick_out(range_tick)
	);

	pbc_sync data_sync_i (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.async_in(data_in),
		.sync_out(data_sync)
	);

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			data_prev_q <= 1'b0;
		end else begin
			data_prev_q <= data_sync;
		end
	end
	assign edge_now = data_sync ^ data_prev_q;

	assign fail_now = (state_q == PBC_CHECK) && ((edge_now && (gap_q < win_lo)) ||
		(gap_q > win_hi));
	assign pass_now = (state_q == PBC_CHECK) && edge_now && !fail_now;

	// defaults, word decode, temporary bit clear
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			opc_q <= OPC_DEFAULT;
			lim_q <= LIM_DEFAULT;
			off_cmd_q <= 1'b0;
		end else begin
			off_cmd_q <= 1'b0;
			if (word_valid_in && word_in[13]) begin
				off_cmd_q <= 1'b1;
			end else if (word_valid_in && word_in[12]) begin
				opc_q <= word_in[11:0];
			end else if (word_valid_in) begin
				lim_q <= word_in[11:0];
			end
			// clear on fail unless rewritten the same cycle
			if (fail_now && !(word_valid_in && !word_in[13] && word_in[12])) begin
				opc_q[OPC_XTEMP_BIT] <= 1'b0;
			end
		end
	end

	// phase sequencer, timers in base periods
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_q <= PBC_SLEEP;
			timer_q <= 28'h0;
			gap_q <= 16'h0;
			tests_q <= 5'h0;
		end else begin
			case (state_q)
				PBC_SLEEP: begin
					if (sleep_cnt == SLEEP_PERMANENT) begin
						timer_q <= 28'h0;
					end else if (timer_q >= sleep_len) begin
						timer_q <= 28'h0;
						state_q <= PBC_WARMUP;
					end else if (base_tick) begin
						timer_q <= timer_q + 28'h1;
					end
				end
				PBC_WARMUP: begin
					if (timer_q >= 28'(WARMUP_CYCLES)) begin
						timer_q <= 28'h0;
						gap_q <= 16'h0;
						tests_q <= 5'h0;
						state_q <= PBC_CHECK;
					end else if (base_tick) begin
						timer_q <= timer_q + 28'h1;
					end
				end
				PBC_CHECK: begin
					if (fail_now) begin
						state_q <= PBC_SLEEP;
					end else if (tests_q >= tests_for(opc_q[OPC_BITCHK_LSB +: 2])) begin
						state_q <= PBC_RECEIVE;
					end else if (pass_now) begin
						gap_q <= 16'h0;
						tests_q <= tests_q + 5'h1;
					end else if (range_tick) begin
						gap_q <= gap_q + 16'h1;
					end
				end
				PBC_RECEIVE: begin
					if (off_cmd_q) begin
						timer_q <= 28'h0;
						state_q <= PBC_SLEEP;
					end
				end
				default: state_q <= PBC_SLEEP;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			processing_enable_out <= 1'b0;
			receiving_out <= 1'b0;
			data_out <= 1'b0;
			operating_config_register_out <= OPC_DEFAULT;
			limit_register_out <= LIM_DEFAULT;
			state_out <= PBC_SLEEP;
		end else begin
			processing_enable_out <= (state_q != PBC_SLEEP);
			receiving_out <= (state_q == PBC_RECEIVE);
			data_out <= (state_q == PBC_RECEIVE) ? data_sync : 1'b0;
			operating_config_register_out <= opc_q;
			limit_register_out <= lim_q;
			state_out <= state_q;
		end
	end

	// Phase hand-overs used by the ordering checks
	sequence sleep_exit_s;
		state_q == PBC_SLEEP ##1 state_q != PBC_SLEEP;
	endsequence
	sequence check_to_recv_s;
		state_q == PBC_CHECK ##1 state_q == PBC_RECEIVE;
	endsequence
	sequence warm_to_check_s;
		state_q == PBC_WARMUP ##1 state_q == PBC_CHECK;
	endsequence

	sleep_disabled_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_SLEEP |=> !processing_enable_out) else $error("processing on in sleep");
	data_gated_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q != PBC_RECEIVE |=> !data_out) else $error("data passed early");
	fail_sleep_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		fail_now |=> state_q == PBC_SLEEP) else $error("fail not to sleep");
	order_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		sleep_exit_s |-> state_q == PBC_WARMUP)
		else $error("bad phase order");
	perm_sleep_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_SLEEP && sleep_cnt == SLEEP_PERMANENT && !word_valid_in
		|=> state_q == PBC_SLEEP) else $error("left permanent sleep");
	temp_clear_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		fail_now && !word_valid_in |=> !opc_q[OPC_XTEMP_BIT]) else $error("temp bit kept");
	recv_count_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		check_to_recv_s |->
		$past(tests_q) >= tests_for($past(opc_q[OPC_BITCHK_LSB +: 2])))
		else $error("receive too soon");
	ignore_edges_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q != PBC_CHECK |-> !pass_now && !fail_now) else $error("edge seen early");

	warmup_on_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_WARMUP |=> processing_enable_out) else $error("warm-up not powered");
	warmup_len_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		warm_to_check_s |-> $past(timer_q) >= 28'(WARMUP_CYCLES))
		else $error("warm-up cut short");
	recv_flag_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_RECEIVE |=> receiving_out) else $error("receiving flag missing");
	data_follow_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_RECEIVE |=> data_out == $past(data_sync)) else $error("data not forwarded");
	off_return_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_RECEIVE && off_cmd_q |=> state_q == PBC_SLEEP)
		else $error("switch-off ignored");
	tally_step_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		pass_now && tests_q < tests_for(opc_q[OPC_BITCHK_LSB +: 2]) |=>
		tests_q == $past(tests_q) + 5'h1) else $error("passing gap not counted");
	tally_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q != PBC_CHECK |=> tests_q == $past(tests_q) || tests_q == 5'h0)
		else $error("tally moved outside validation");
	perm_timer_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_SLEEP && sleep_cnt == SLEEP_PERMANENT |=> timer_q == 28'h0)
		else $error("permanent sleep timer ran");
	gap_over_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_CHECK && gap_q > win_hi |=> state_q == PBC_SLEEP)
		else $error("long gap accepted");
	short_gap_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == PBC_CHECK && edge_now && gap_q < win_lo |=> state_q == PBC_SLEEP)
		else $error("short gap accepted");
	strap_once_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		strap_taken_q |=> $stable(strap_q)) else $error("strap ratio changed");
endmodule : pbc_sequencer

// *** rtl/pbc_sync.sv ***
`timescale 1ns/10ps
module pbc_sync (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pbc_sync
